// ---- src/tcp_parser.sv ----
// Function
// - each buffer starts with command word a then b, then payload
// - second word differing from the frame's first buffer sets error
// - tag of second word goes into the frame status entry
// - completion bit set raises loaded flag when buffer fully loaded
// - loaded flag may be routed to the interrupt output by a mask
// - bits 25:24 select end alignment 4, 16 or 32 bytes; 11 reserved
// - padding words are dropped, only buffer data passes on
// - retained word count covers only data passed on
// - bits 20:16 give a start byte offset; earlier bytes ignored
// - bit 13 marks first buffer, bit 12 marks last buffer
// - byte counts summed per frame, mismatch to frame length is error
// - tag taken from bits 31:16 of the second word, any value
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

module tcp_parser
    import tcp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [31:0] fifo_data_o,
    output logic [3:0] fifo_byte_en_o,
    output logic fifo_valid_o,
    output logic fifo_last_o,
    output logic [15:0] stat_tag_o,
    output logic stat_error_o,
    output logic stat_valid_o,
    output logic irq_o
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // words covering offset plus payload bytes
    function automatic logic [9:0] span_words(
        input logic [11:0] span
    );
        logic [12:0] s;
        s = {1'b0, span} + 13'h0003;
        return s[11:2];
    endfunction

    // data words rounded up to the end alignment
    function automatic logic [9:0] padded_words(
        input logic [9:0] dw,
        input logic [1:0] align
    );
        logic [10:0] r;
        r = {1'b0, dw};
        case (align)
            `TCP_ALIGN_16: begin
                r = ({1'b0, dw} + 11'h003) & 11'h7FC;
            end
            `TCP_ALIGN_32: begin
                r = ({1'b0, dw} + 11'h007) & 11'h7F8;
            end
            default: begin
                r = {1'b0, dw};
            end
        endcase
        return r[9:0];
    endfunction

    // byte lanes of word widx inside [off, span)
    function automatic logic [3:0] lane_mask(
        input logic [9:0] widx,
        input logic [4:0] off,
        input logic [11:0] span
    );
        logic [3:0] m;
        logic [11:0] pos;
        m = 4'h0;
        for (int l = 0; l < 4; l++) begin
            pos = {widx, 2'b00} + 12'(l);
            m[l] = (pos >= {7'h00, off}) && (pos < span);
        end
        return m;
    endfunction

    // true on the final word of a run of count words
    function automatic logic at_end(
        input logic [9:0] widx,
        input logic [9:0] count
    );
        return widx == count - 10'h001;
    endfunction

    // frame tag field of a second command word
    function automatic logic [15:0] frame_tag(
        input logic [31:0] b
    );
        return b[`TCP_B_TAG_HI:`TCP_B_TAG_LO];
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------

    tcp_state_s s_q;
    tcp_state_s s_d;

    logic [4:0] a_off;
    logic [10:0] a_size;
    logic [11:0] a_span;
    logic [1:0] a_align;
    logic a_first;
    logic a_last;
    logic a_ioc;
    logic [11:0] new_sum;
    logic [3:0] be;
    logic data_wr;
    logic buf_end;
    logic b_bad;
    logic [9:0] a_words;

    // ---------------------------------------------------------------
    // command fields
    // ---------------------------------------------------------------

    assign a_off = s_q.cmd_a[`TCP_A_OFF_HI:`TCP_A_OFF_LO];
    assign a_size = s_q.cmd_a[`TCP_A_SIZE_HI:`TCP_A_SIZE_LO];
    assign a_span = {7'h00, a_off} + {1'b0, a_size};
    assign a_words = span_words(a_span);
    assign a_align = s_q.cmd_a[`TCP_A_ALIGN_HI:`TCP_A_ALIGN_LO];
    assign a_first = s_q.cmd_a[`TCP_A_FIRST];
    assign a_last = s_q.cmd_a[`TCP_A_LAST];
    assign a_ioc = s_q.cmd_a[`TCP_A_IOC];
    assign data_wr = wr_i && (addr_i == `TCP_ADDR_DATA);
    assign be = lane_mask(s_q.widx, a_off, a_span);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------

    always_comb begin
        s_d = s_q;
        s_d.word.valid = 1'b0;
        s_d.word.last = 1'b0;
        s_d.stat.valid = 1'b0;
        new_sum = (a_first ? 12'h000 : s_q.len_sum) + {1'b0, a_size};
        buf_end = 1'b0;
        b_bad = 1'b0;

        // hardware-set bits and w1c; set wins over clear
        if (wr_i && addr_i == `TCP_ADDR_STATUS) begin
            s_d.status = s_q.status & ~wdata_i[1:0];
        end
        if (wr_i && addr_i == `TCP_ADDR_MASK) begin
            s_d.mask = wdata_i[1:0];
        end
        if (wr_i && addr_i == `TCP_ADDR_RETAINED) begin
            s_d.retained = 16'h0000;
        end

        if (data_wr) begin
            case (s_q.phase)
                PH_CMD_A: begin
                    s_d.cmd_a = wdata_i;
                    s_d.phase = PH_CMD_B;
                end
                PH_CMD_B: begin
                    s_d.widx = 10'h000;
                    s_d.dwords = a_words;
                    s_d.twords = padded_words(a_words, a_align);
                    s_d.len_sum = new_sum;
                    // checks run on word b, before any payload arrives
                    if (a_first) begin
                        s_d.first_b = wdata_i;
                        s_d.in_frame = 1'b1;
                        s_d.frame_err = 1'b0;
                    end else if (!s_q.in_frame) begin
                        b_bad = 1'b1;
                    end else if (wdata_i != s_q.first_b) begin
                        b_bad = 1'b1;
                    end
                    if (a_align == 2'h3) begin
                        b_bad = 1'b1;
                    end
                    if (a_last &&
                        new_sum != {1'b0, wdata_i[`TCP_B_LEN_HI:
                                                  `TCP_B_LEN_LO]}) begin
                        b_bad = 1'b1;
                    end
                    if (a_first) begin
                        s_d.frame_err = b_bad;
                    end else begin
                        s_d.frame_err = s_q.frame_err | b_bad;
                    end
                    if (a_words == 10'h000) begin
                        buf_end = 1'b1;
                        s_d.phase = PH_CMD_A;
                    end else begin
                        s_d.phase = PH_DATA;
                    end
                end
                PH_DATA: begin
                    s_d.widx = s_q.widx + 10'h001;
                    if (s_q.widx < s_q.dwords && be != 4'h0) begin
                        s_d.word.valid = 1'b1;
                        s_d.word.data = wdata_i;
                        s_d.word.byte_en = be;
                        s_d.word.last = a_last &&
                            at_end(s_q.widx, s_q.dwords);
                        s_d.retained = s_q.retained + 16'h0001;
                    end
                    // loaded once the last payload word is in, pad or not
                    if (at_end(s_q.widx, s_q.dwords)) begin
                        buf_end = 1'b1;
                    end
                    if (at_end(s_q.widx, s_q.twords)) begin
                        s_d.phase = PH_CMD_A;
                    end
                end
                default: begin
                    s_d.phase = PH_CMD_A;
                end
            endcase
        end

        if (b_bad) begin
            s_d.status[`TCP_BIT_ERROR] = 1'b1;
        end

        // buffer fully loaded
        if (buf_end) begin
            if (a_ioc) begin
                s_d.status[`TCP_BIT_LOADED] = 1'b1;
            end
            if (a_last) begin
                s_d.in_frame = 1'b0;
                s_d.stat.valid = 1'b1;
                s_d.stat.tag = frame_tag(s_d.first_b);
                s_d.stat.error = s_d.frame_err;
                s_d.last_tag = frame_tag(s_d.first_b);
            end
        end

        // register read, data one cycle later
        s_d.rdata = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                `TCP_ADDR_STATUS: begin
                    s_d.rdata = {30'h0, s_q.status};
                end
                `TCP_ADDR_MASK: begin
                    s_d.rdata = {30'h0, s_q.mask};
                end
                `TCP_ADDR_RETAINED: begin
                    s_d.rdata = {16'h0000, s_q.retained};
                end
                `TCP_ADDR_TAG: begin
                    s_d.rdata = {16'h0000, s_q.last_tag};
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.phase <= PH_CMD_A;
            s_q.status <= `TCP_STATUS_RST;
            s_q.mask <= `TCP_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------

    assign rdata_o = s_q.rdata;
    assign fifo_data_o = s_q.word.data;
    assign fifo_byte_en_o = s_q.word.byte_en;
    assign fifo_valid_o = s_q.word.valid;
    assign fifo_last_o = s_q.word.last;
    assign stat_tag_o = s_q.stat.tag;
    assign stat_error_o = s_q.stat.error;
    assign stat_valid_o = s_q.stat.valid;
    // level output, high while any unmasked status bit stands
    assign irq_o = |(s_q.status & s_q.mask);

endmodule

`default_nettype wire

// ---- common/tcp_params.svh ----
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// register offsets (byte addresses)
`define TCP_ADDR_DATA 8'h00
`define TCP_ADDR_STATUS 8'h04
`define TCP_ADDR_MASK 8'h08
`define TCP_ADDR_RETAINED 8'h0C
`define TCP_ADDR_TAG 8'h10

// status / mask bit positions
`define TCP_BIT_LOADED 0
`define TCP_BIT_ERROR 1

// command word a fields
`define TCP_A_IOC 31
`define TCP_A_ALIGN_HI 25
`define TCP_A_ALIGN_LO 24
`define TCP_A_OFF_HI 20
`define TCP_A_OFF_LO 16
`define TCP_A_FIRST 13
`define TCP_A_LAST 12
`define TCP_A_SIZE_HI 10
`define TCP_A_SIZE_LO 0

// command word b fields
`define TCP_B_TAG_HI 31
`define TCP_B_TAG_LO 16
`define TCP_B_LEN_HI 10
`define TCP_B_LEN_LO 0

// end alignment codes
`define TCP_ALIGN_4 2'h0
`define TCP_ALIGN_16 2'h1
`define TCP_ALIGN_32 2'h2

// reset values
`define TCP_STATUS_RST 2'h0
`define TCP_MASK_RST 2'h0

`endif

// ---- common/tcp_pkg.sv ----
package tcp_pkg;

    typedef enum logic [2:0] {
        PH_CMD_A = 3'b001,
        PH_CMD_B = 3'b010,
        PH_DATA = 3'b100
    } tcp_phase_e;

    // word passed on toward the transmit fifo
    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [3:0] byte_en;
        logic last;
    } tcp_word_s;

    // per-frame status entry
    typedef struct packed {
        logic valid;
        logic [15:0] tag;
        logic error;
    } tcp_status_s;

    typedef struct packed {
        tcp_phase_e phase;
        logic [31:0] cmd_a;
        logic [31:0] first_b;
        logic in_frame;
        logic frame_err;
        logic [11:0] len_sum;
        logic [9:0] widx;
        logic [9:0] dwords;
        logic [9:0] twords;
        logic [1:0] status;
        logic [1:0] mask;
        logic [15:0] retained;
        logic [15:0] last_tag;
        logic [31:0] rdata;
        tcp_word_s word;
        tcp_status_s stat;
    } tcp_state_s;

endpackage

// ---- dv/tcp_parser_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcp_parser_assertions (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [3:0] fifo_byte_en_o,
    input wire logic fifo_valid_o,
    input wire logic fifo_last_o,
    input wire logic stat_valid_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence data_wr;
        wr_i && addr_i == 8'h00;
    endsequence
    sequence no_data_wr;
        !(wr_i && addr_i == 8'h00);
    endsequence
    a_stream_idle: assert property (
        no_data_wr |=> !fifo_valid_o && !stat_valid_o)
        else $error("stream output without data write");
    a_stat_word: assert property (
        data_wr ##1 stat_valid_o |-> !fifo_valid_o || fifo_last_o)
        else $error("frame status on a non-final word");
    a_last_status: assert property (
        fifo_valid_o && fifo_last_o |-> stat_valid_o)
        else $error("last word without frame status");
    a_lanes_used: assert property (
        fifo_valid_o |-> fifo_byte_en_o != 4'h0)
        else $error("word passed with no payload lanes");
    a_stat_once: assert property (stat_valid_o |=> !stat_valid_o)
        else $error("frame status twice in a row");
    a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_irq_rise: assert property ($rose(irq_o) |-> $past(wr_i))
        else $error("interrupt rose without a write");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i))
        else $error("interrupt fell without a write");
endmodule

bind tcp_parser tcp_parser_assertions chk_u (.ref_clk_i, .reset_i, .addr_i,
    .wr_i, .rd_i, .rdata_o, .fifo_byte_en_o, .fifo_valid_o, .fifo_last_o,
    .stat_valid_o, .irq_o);
`default_nettype wire

// ---- dv/tcp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcp_host_model (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // released data lines show the inverse, not the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
    // word a, word b, then payload and padding to the end alignment
    task automatic send(input logic [31:0] a,
                        input logic [31:0] b);
        int n;
        int al;
        al = (a[25:24] == 2'h2) ? 8 : (a[25:24] == 2'h1) ? 4 : 1;
        n = (32'(a[20:16]) + 32'(a[10:0]) + 3) / 4;
        n = (n + al - 1) / al * al;
        wr(8'h00, a);
        wr(8'h00, b);
        repeat (n) wr(8'h00, $urandom);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_tx_command_buffer_parser.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("BAD %0t got %0h exp %0h", $time, g, e); \
    end \
end
module tb_tx_command_buffer_parser;
    logic ref_clk_i;
    logic reset_i;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, fdata, rv, wd_q;
    logic [3:0] fbe, lbe;
    logic wr, rd, fvalid, flast, svalid, serr, irq, nerr;
    logic [15:0] stag, ntag;
    int num_errors, checked, nwords, nstat;

    tcp_parser dut_u (.ref_clk_i, .reset_i, .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fifo_data_o(fdata),
        .fifo_byte_en_o(fbe), .fifo_valid_o(fvalid), .fifo_last_o(flast),
        .stat_tag_o(stag), .stat_error_o(serr), .stat_valid_o(svalid),
        .irq_o(irq));
    tcp_host_model host_u (.clk_i(ref_clk_i), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (fvalid === 1'b1) begin
            nwords++;
            `CHK(fdata, wd_q)
        end
        wd_q <= wdata;
        if (fvalid === 1'b1 && flast === 1'b1) lbe = fbe;
        if (svalid === 1'b1) begin
            nstat++;
            ntag = stag;
            nerr = serr;
        end
    end

    function automatic int exp_words(int off, int sz);
        return (off + sz + 3) / 4 - off / 4;
    endfunction
    function automatic logic [3:0] last_be(int off, int sz);
        int e;
        e = off + sz - 1;
        for (int l = 0; l < 4; l++)
            last_be[l] = (4 * (e / 4) + l >= off) && (4 * (e / 4) + l <= e);
    endfunction
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        host_u.rd(a, rv);
        `CHK(rv, e)
    endtask
    task automatic finish_test;
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // bad: 0 clean, 1 word b differs, 2 length off by one, 3 align 11
    task automatic frame(input int nb, input int bad);
        int sz[3], off[3], tot, w, n0;
        logic [1:0] al[3];
        logic [15:0] tag;
        logic [1:0] msk;
        logic ioc;
        logic [31:0] a, b;
        tot = 0;
        w = 0;
        tag = 16'($urandom);
        ioc = 1'($urandom);
        msk = 2'($urandom);
        host_u.wr(8'h08, {30'h0, msk});
        host_u.wr(8'h0C, 32'h0);
        rchk(8'h08, {30'h0, msk});
        rchk(8'h0C, 32'h0);
        nwords = 0;
        n0 = nstat;
        lbe = 'x;
        ntag = 'x;
        nerr = 'x;
        for (int i = 0; i < nb; i++) begin
            sz[i] = $urandom_range(40, 1);
            off[i] = $urandom_range(31, 0);
            al[i] = (bad == 3) ? 2'h3 : 2'($urandom_range(2, 0));
            tot += sz[i];
            w += exp_words(off[i], sz[i]);
        end
        b = {tag, 5'h0, 11'(tot + (bad == 2 ? 1 : 0))};
        for (int i = 0; i < nb; i++) begin
            a = {ioc, 5'h0, al[i], 3'h0, 5'(off[i]), 2'h0, 1'(i == 0),
                1'(i == nb - 1), 1'b0, 11'(sz[i])};
            host_u.send(a, (bad == 1 && i > 0) ? b ^ 32'h0001_0000 : b);
        end
        rchk(8'h04, {30'h0, 1'(bad != 0), ioc});
        `CHK(irq, |({1'(bad != 0), ioc} & msk))
        `CHK(nstat, n0 + 1)
        `CHK(ntag, tag)
        `CHK(nerr, 1'(bad != 0))
        rchk(8'h10, {16'h0, tag});
        if (bad == 0) begin
            `CHK(nwords, w)
            rchk(8'h0C, 32'(w));
            `CHK(lbe, last_be(off[nb - 1], sz[nb - 1]))
        end
        host_u.wr(8'h04, 32'h3);
        rchk(8'h04, 32'h0);
        `CHK(irq, 1'b0)
    endtask

    initial begin
        #1000000;
        num_errors++;
        finish_test;
    end
    initial begin
        num_errors = 0;
        checked = 0;
        nstat = 0;
        reset_i = 1'b1;
        void'($urandom(83772));
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rchk(8'h04, 32'h0);
        rchk(8'h08, 32'h0);
        rchk(8'h14, 32'h0);
        host_u.wr(8'h18, 32'hFFFF_FFFF);
        for (int i = 0; i < 40; i++) frame($urandom_range(3, 1), 0);
        frame(2, 1);
        frame(1, 2);
        frame(3, 2);
        frame(1, 3);
        // lone word a, then a reset in mid-buffer
        host_u.wr(8'h00, 32'h0000_3001);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        `CHK(irq, 1'b0)
        frame(1, 0);
        finish_test;
    end
endmodule
`default_nettype wire
